// ==== mce_pkg.sv ====
// Package: constants, register layouts and operator codes of the evaluator
// Summary of operation
// - Five independent math instances, each selectable source
// - Each instance takes six scaled selectable inputs
// - Inputs mapped min..max to percent, gain applied
// - Four chained stages; later stages select B only
// - Stage B source zero passes A unchanged
// - Codes 0-5 are the six comparisons
// - Codes 6-8 are OR, AND, XOR
// - Codes 9-14 add, sub, mul, div, min, max
// - Logic operand true when one or more
// - Codes 0-8 give exactly zero or one
// - Arithmetic results saturate at full scale
// - Zero divisor gives full scale result
// - Result percent mapped to output min..max units
// - Two conditions combined by a logic operator
// - Unselected argument presents zero
// - Condition codes 0-7: compares, OR, AND
// - Condition operators reset to OR
// - Combiner accepts only OR, AND, XOR codes
package mce_pkg;
  localparam int N_MATH = 5;
  localparam int N_IN = 6;
  localparam int N_STAGE = 4;
  localparam int N_COND = 2;
  localparam int N_SIG = 8;
  localparam int N_WORD = 16;
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [15:0] LOGIC_TRUE = 16'h0001;
  localparam logic [15:0] LOGIC_ZERO = 16'h0000;
  localparam int GAIN_FRAC = 8;
  localparam int CLK_MHZ = 40;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_MATH0 = 4'h9;
  localparam logic [3:0] W_ISRC0 = 4'h6;
  localparam logic [3:0] W_STAGE = 4'hC;
  localparam logic [3:0] W_OUT = 4'hD;
  localparam logic [3:0] W_RES = 4'hE;
  localparam logic [3:0] W_CTRL = 4'hF;
  localparam logic [3:0] CW_CFG = 4'h0;
  localparam logic [3:0] CW_RES = 4'h1;
  localparam logic [31:0] RST_LIM = 32'h2710_0000;
  localparam logic [31:0] RST_ISRC = 32'h0100_0000;
  localparam logic [31:0] RST_OUT = 32'h2710_0000;
  localparam logic [31:0] RST_COND = 32'h0036_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_OR,
    OP_AND, OP_XOR, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MIN, OP_MAX,
    OP_RSV} mce_op_type;
  typedef enum logic [1:0] {CMB_OR, CMB_AND, CMB_XOR, CMB_RSV} mce_cmb_type;

  typedef struct packed {
    logic [1:0] hi;
    logic cond;
    logic [2:0] blk;
    logic [3:0] word;
    logic [1:0] lo;
  } mce_addr_type;
  typedef struct packed {logic [15:0] max; logic [15:0] min;} mce_lim_type;
  typedef struct packed {
    logic [15:0] gain;
    logic [11:0] pad;
    logic [3:0] src;
  } mce_isrc_type;
  typedef struct packed {
    logic pad;
    logic [N_STAGE-1:0][2:0] sel_b;
    logic [2:0] sel_a;
    logic [N_STAGE-1:0][3:0] op;
  } mce_stage_type;
  typedef struct packed {
    logic [7:0] pad;
    mce_cmb_type op3;
    logic [2:0] op2;
    logic [2:0] op1;
    logic [3:0] c2a2;
    logic [3:0] c2a1;
    logic [3:0] c1a2;
    logic [3:0] c1a1;
  } mce_cond_type;
  typedef struct packed {logic [15:0] units; logic [15:0] pct;} mce_res_type;
endpackage

// ==== mce_top.sv ====
// Math blocks and conditional blocks with an APB register file
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module mce_top
  import mce_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [N_SIG-1:0][15:0] sig_in,
  output mce_res_type [N_MATH-1:0] math_res,
  output logic [N_COND-1:0] cond_out,
  output logic eval_done
);
  localparam int TICK_SPAN = TICK_CYC;

  logic [31:0] mreg_r [N_MATH][N_WORD];
  mce_cond_type creg_r [N_COND];
  mce_cond_type wcfg;
  mce_cond_type cfg_nxt;
  logic [5:0] tick_cnt_r;
  logic tick;
  logic eval_r;
  logic cond_eval_r;
  logic [N_SIG-1:0][15:0] samp_r;
  mce_res_type [N_MATH-1:0] res_r;
  mce_res_type [N_MATH-1:0] res_nxt;
  logic [N_COND-1:0] cond_r;
  logic [N_COND-1:0] cond_nxt;
  logic [N_COND-1:0] c1_w;
  logic [N_COND-1:0] c2_w;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic mapped;
  logic wr_en;
  logic [15:0] a0_w;
  logic [15:0] b0_w;
  mce_addr_type adr;

  function automatic logic [15:0] sat_full(input logic [31:0] v);
    return (v > 32'(PCT_FULL)) ? PCT_FULL : v[15:0];
  endfunction

  function automatic logic [15:0] scale_in(input logic [15:0] raw,
    input mce_lim_type lim, input logic [15:0] gain);
    logic [31:0] base;
    logic [31:0] g;
    base = 32'(PCT_FULL);
    if (raw <= lim.min)
      base = '0;
    else if (raw < lim.max)
      base = (32'(raw - lim.min) * 32'(PCT_FULL)) / 32'(lim.max - lim.min);
    g = (base * 32'(gain)) >> GAIN_FRAC;
    return sat_full(g);
  endfunction

  function automatic logic [15:0] math_op(input mce_op_type op,
    input logic [15:0] a, input logic [15:0] b);
    logic ta;
    logic tb;
    logic [15:0] r;
    ta = (a >= LOGIC_TRUE);
    tb = (b >= LOGIC_TRUE);
    r = a;
    unique case (op)
      OP_EQ: r = (a == b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_NE: r = (a != b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_GT: r = (a > b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_GE: r = (a >= b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_LT: r = (a < b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_LE: r = (a <= b) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_OR: r = (ta || tb) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_AND: r = (ta && tb) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_XOR: r = (ta != tb) ? LOGIC_TRUE : LOGIC_ZERO;
      OP_ADD: r = sat_full(32'(a) + 32'(b));
      OP_SUB: r = (a > b) ? sat_full(32'(a - b)) : LOGIC_ZERO;
      OP_MUL: r = sat_full((32'(a) * 32'(b)) / 32'(PCT_FULL));
      OP_DIV: r = (b == LOGIC_ZERO) ? PCT_FULL
        : sat_full((32'(a) * 32'(PCT_FULL)) / 32'(b));
      OP_MIN: r = (a < b) ? a : b;
      OP_MAX: r = (a > b) ? a : b;
      OP_RSV: r = a;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] pick(input logic [2:0] sel,
    input logic [N_IN-1:0][15:0] sc);
    // Index 0 means no input; codes beyond six also read zero
    return (sel == 3'h0 || 32'(sel) > N_IN) ? LOGIC_ZERO
      : sc[3'(sel - 3'h1)];
  endfunction

  function automatic logic [15:0] src_val(input logic [3:0] code,
    input logic [N_SIG-1:0][15:0] s, input mce_res_type [N_MATH-1:0] m);
    logic [15:0] v;
    v = LOGIC_ZERO;
    if (code != SRC_NONE && 32'(code) <= N_SIG)
      v = s[3'(code - 4'h1)];
    else if (code >= SRC_MATH0 && 32'(code - SRC_MATH0) < N_MATH)
      v = m[3'(code - SRC_MATH0)].units;
    return v;
  endfunction

  // Evaluation tick and input sampling
  assign tick = (tick_cnt_r == TICK_LAST);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 6'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      samp_r <= '0;
      eval_r <= 1'b0;
      cond_eval_r <= 1'b0;
    end
    else
    begin
      if (tick)
        samp_r <= sig_in;
      eval_r <= tick;
      cond_eval_r <= eval_r;
    end
  end

  // Math datapath, all five instances in parallel
  always_comb
  begin
    logic [N_IN-1:0][15:0] sc;
    logic [15:0] acc;
    logic [15:0] span;
    mce_stage_type st;
    mce_lim_type ol;
    mce_isrc_type is;
    sc = '0;
    acc = '0;
    span = '0;
    st = '0;
    ol = '0;
    is = '0;
    a0_w = '0;
    b0_w = '0;
    for (int m = 0; m < N_MATH; m++)
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        is = mce_isrc_type'(mreg_r[m][32'(W_ISRC0) + i]);
        sc[i] = scale_in(src_val(is.src, samp_r, '0),
          mce_lim_type'(mreg_r[m][i]), is.gain);
      end
      st = mce_stage_type'(mreg_r[m][W_STAGE]);
      acc = pick(st.sel_a, sc);
      if (m == 0)
      begin
        a0_w = acc;
        b0_w = pick(st.sel_b[0], sc);
      end
      for (int s = 0; s < N_STAGE; s++)
      begin
        if (st.sel_b[s] != 3'h0)
          acc = math_op(mce_op_type'(st.op[s]), acc,
            pick(st.sel_b[s], sc));
      end
      ol = mce_lim_type'(mreg_r[m][W_OUT]);
      span = (ol.max > ol.min) ? ol.max - ol.min : LOGIC_ZERO;
      res_nxt[m].pct = mreg_r[m][W_CTRL][0] ? acc : LOGIC_ZERO;
      res_nxt[m].units = ol.min + 16'((32'(res_nxt[m].pct) * 32'(span))
        / 32'(PCT_FULL));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      res_r <= '0;
    else if (eval_r)
      res_r <= res_nxt;
  end

  // Conditional blocks, fed from the registered math results
  always_comb
  begin
    mce_cond_type cf;
    cf = '0;
    for (int c = 0; c < N_COND; c++)
    begin
      cf = mce_cond_type'(creg_r[c]);
      c1_w[c] = math_op(mce_op_type'({1'b0, cf.op1}),
        src_val(cf.c1a1, samp_r, res_r),
        src_val(cf.c1a2, samp_r, res_r)) != LOGIC_ZERO;
      c2_w[c] = math_op(mce_op_type'({1'b0, cf.op2}),
        src_val(cf.c2a1, samp_r, res_r),
        src_val(cf.c2a2, samp_r, res_r)) != LOGIC_ZERO;
      unique case (cf.op3)
        CMB_OR: cond_nxt[c] = c1_w[c] | c2_w[c];
        CMB_AND: cond_nxt[c] = c1_w[c] & c2_w[c];
        CMB_XOR: cond_nxt[c] = c1_w[c] ^ c2_w[c];
        CMB_RSV: cond_nxt[c] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cond_r <= '0;
    else if (cond_eval_r)
      cond_r <= cond_nxt;
  end

  assign math_res = res_r;
  assign cond_out = cond_r;
  assign eval_done = cond_eval_r;

  // APB slave, zero wait states
  assign adr = mce_addr_type'(paddr);
  assign mapped = (adr.hi == 2'h0) && (adr.lo == 2'h0) && (adr.cond
    ? (32'(adr.blk) < N_COND && adr.word <= CW_RES)
    : (32'(adr.blk) < N_MATH));
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    rd_nxt = '0;
    if (mapped && adr.cond)
      rd_nxt = (adr.word == CW_CFG) ? creg_r[adr.blk[0]]
        : {31'h0, cond_r[adr.blk[0]]};
    else if (mapped)
      rd_nxt = (adr.word == W_RES) ? res_r[adr.blk]
        : mreg_r[adr.blk][adr.word];
  end

  // Loaded in the setup cycle so the access phase sees a flop output
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prdata_r <= '0;
    else if (psel && !penable)
      prdata_r <= rd_nxt;
  end

  assign prdata = prdata_r;

  function automatic logic [31:0] rst_word(input int w);
    logic [31:0] v;
    v = RST_ZERO;
    if (w < N_IN)
      v = RST_LIM;
    else if (w < 2 * N_IN)
      v = RST_ISRC;
    else if (w == 32'(W_OUT))
      v = RST_OUT;
    return v;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int m = 0; m < N_MATH; m++)
        for (int w = 0; w < N_WORD; w++)
          mreg_r[m][w] <= rst_word(w);
    end
    else if (wr_en && !adr.cond && adr.word != W_RES)
      mreg_r[adr.blk][adr.word] <= pwdata;
  end

  // Reserved combiner code keeps the old operator, so a bad write
  // cannot leave the block without a defined combine
  assign wcfg = mce_cond_type'(pwdata);

  always_comb
  begin
    cfg_nxt = wcfg;
    if (wcfg.op3 == CMB_RSV)
      cfg_nxt.op3 = creg_r[adr.blk[0]].op3;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int c = 0; c < N_COND; c++)
        creg_r[c] <= mce_cond_type'(RST_COND);
    end
    else if (wr_en && adr.cond && adr.word == CW_CFG)
      creg_r[adr.blk[0]] <= cfg_nxt;
  end

  // Checks
  mce_stage_type st0;
  assign st0 = mce_stage_type'(mreg_r[0][W_STAGE]);

  a_tick_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tick |-> ##TICK_SPAN tick)
    else $error("tick period wrong");

  a_sample_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !tick |=> $stable(samp_r))
    else $error("samples changed between ticks");

  a_pct_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    eval_r |=> res_r[0].pct <= PCT_FULL)
    else $error("math percent beyond full scale");

  a_pass_thru: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (eval_r && mreg_r[0][W_CTRL][0] && st0.sel_b == '0)
    |=> res_r[0].pct == $past(a0_w))
    else $error("unused stages did not pass operand");

  a_div_full: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (eval_r && mreg_r[0][W_CTRL][0] && st0.op[0] == OP_DIV
    && st0.sel_b[0] != 3'h0 && b0_w == LOGIC_ZERO
    && st0.sel_b[N_STAGE-1:1] == '0)
    |=> res_r[0].pct == PCT_FULL)
    else $error("zero divisor not full scale");

  a_logic_bin: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (eval_r && st0.op[0] <= OP_XOR && st0.sel_b[0] != 3'h0
    && st0.sel_b[N_STAGE-1:1] == '0)
    |=> res_r[0].pct <= LOGIC_TRUE)
    else $error("logic result not zero or one");

  a_units_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    eval_r ##1 (res_r[0].pct == PCT_FULL && mreg_r[0][W_OUT][31:16]
    > mreg_r[0][W_OUT][15:0])
    |-> res_r[0].units == mreg_r[0][W_OUT][31:16])
    else $error("full scale not mapped to output max");

  a_cond_reset: assert property (@(posedge sys_clk)
    sys_rst |=> creg_r[0].op1 == 3'(OP_OR)
    && creg_r[0].op2 == 3'(OP_OR))
    else $error("condition operators not OR after reset");

  a_cmb_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_en && adr.cond && adr.word == CW_CFG && adr.blk == 3'h0
    && wcfg.op3 == CMB_RSV)
    |=> $stable(creg_r[0].op3))
    else $error("reserved combiner code accepted");

  a_cond_xor: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cond_eval_r && creg_r[0].op3 == CMB_XOR)
    |=> cond_out[0] == $past(c1_w[0] ^ c2_w[0]))
    else $error("xor combine wrong");

  a_sub_floor: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (eval_r && mreg_r[0][W_CTRL][0] && st0.op[0] == OP_SUB
    && st0.sel_b[0] != 3'h0 && st0.sel_b[N_STAGE-1:1] == '0
    && b0_w >= a0_w)
    |=> res_r[0].pct == LOGIC_ZERO)
    else $error("difference not floored at zero");

  a_add_sat: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (eval_r && mreg_r[0][W_CTRL][0] && st0.op[0] == OP_ADD
    && st0.sel_b[0] != 3'h0 && st0.sel_b[N_STAGE-1:1] == '0
    && 17'(a0_w) + 17'(b0_w) >= 17'(PCT_FULL))
    |=> res_r[0].pct == PCT_FULL)
    else $error("sum not saturated at full scale");

  a_unsel_zero: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (creg_r[0].c2a1 == SRC_NONE && creg_r[0].c2a2 == SRC_NONE
    && creg_r[0].op2 == 3'(OP_EQ)) |-> c2_w[0])
    else $error("unselected arguments not zero");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the math and condition evaluator
`timescale 1ns/1ps
module tb_top;
  import mce_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [N_SIG-1:0][15:0] sig_in = '0;
  mce_res_type [N_MATH-1:0] math_res;
  logic [N_COND-1:0] cond_out;
  logic eval_done;
  int n_mismatch = 0;
  int total_checks = 0;
  int gap = 0;
  int va[4] = '{3000, 5000, 8000, 7000};
  int vb[4] = '{5000, 5000, 3000, 0};
  logic [31:0] rd;
  logic err;
  logic [15:0] e;
  logic c;

  mce_top dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .sig_in(sig_in),
    .math_res(math_res),
    .cond_out(cond_out),
    .eval_done(eval_done)
  );

  always #12.5 sys_clk = ~sys_clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Master waits on pready; never assumes zero wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
    begin
      n_mismatch++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Two ticks so the second one sees config and inputs
  task wait_eval;
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (eval_done !== 1'b1 && n < 100);
      if (n >= 100)
      begin
        n_mismatch++;
        stop_test;
      end
      gap = n;
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [15:0] fm(input int op, input int a, input int b);
    int r;
    case (op)
      0: r = a == b;
      1: r = a != b;
      2: r = a > b;
      3: r = a >= b;
      4: r = a < b;
      5: r = a <= b;
      6: r = (a >= 1) || (b >= 1);
      7: r = (a >= 1) && (b >= 1);
      8: r = (a >= 1) != (b >= 1);
      9: r = a + b;
      10: r = (a > b) ? a - b : 0;
      11: r = a * b / 10000;
      12: r = (b == 0) ? 10000 : a * 10000 / b;
      13: r = (a < b) ? a : b;
      14: r = (a > b) ? a : b;
      default: r = 0;
    endcase
    if (r > 10000)
      r = 10000;
    return 16'(r);
  endfunction

  function automatic logic [31:0] ccfg(input int o1, input int o2, int o3);
    return 32'h21 | (32'(o1) << 16) | (32'(o2) << 19) | (32'(o3) << 22);
  endfunction

  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, RST_LIM);
    apb(1'b0, 12'h018, 32'h0);
    check(rd, RST_ISRC);
    apb(1'b0, 12'h034, 32'h0);
    check(rd, RST_OUT);
    apb(1'b0, 12'h200, 32'h0);
    check(rd, RST_COND);
    check({26'h0, rd[21:16]}, {26'h0, 3'h6, 3'h6});
    apb(1'b0, 12'h140, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h13C, 32'h0);
    check({31'h0, err}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
      apb(1'b1, 12'h018 + 12'(4 * i), {16'h0100, 12'h000, 4'(i + 1)});
    apb(1'b1, 12'h03C, 32'h1);
    for (int p = 0; p < 4; p++)
      for (int op = 0; op < 15; op++)
      begin
        apb(1'b1, 12'h030, 32'h0011_0000 | 32'(op));
        sig_in[0] <= 16'(va[p]);
        sig_in[1] <= 16'(vb[p]);
        wait_eval;
        e = fm(op, va[p], vb[p]);
        check(math_res[0], {e, e});
        check(math_res[1], 32'h0);
      end
    check(32'(gap), 32'(TICK_CYC));
    $display("test math ops done");
    // Input 3: window 1000..3000, gain 1.5; output 100..1100
    apb(1'b1, 12'h008, {16'h0BB8, 16'h03E8});
    apb(1'b1, 12'h020, {16'h0180, 12'h000, 4'h3});
    apb(1'b1, 12'h034, {16'h044C, 16'h0064});
    apb(1'b1, 12'h030, 32'h00D1_6AB9);
    sig_in[0] <= 16'h0BB8;
    sig_in[1] <= 16'h07D0;
    sig_in[2] <= 16'h07D0;
    wait_eval;
    check(math_res[0], {16'h01DB, 16'h0EA6});
    apb(1'b1, 12'h038, 32'hFFFF_FFFF);
    apb(1'b0, 12'h038, 32'h0);
    check(rd, {16'h01DB, 16'h0EA6});
    apb(1'b1, 12'h030, 32'h0001_0000);
    wait_eval;
    check(math_res[0], {16'h0190, 16'h0BB8});
    $display("test chain done");
    for (int p = 0; p < 4; p++)
      for (int op = 0; op < 8; op++)
      begin
        apb(1'b1, 12'h200, ccfg(op, 1, 0));
        sig_in[0] <= 16'(va[p]);
        sig_in[1] <= 16'(vb[p]);
        wait_eval;
        c = (op < 6) ? fm(op, va[p], vb[p]) != 0 :
          (op == 6) ? (va[p] != 0 || vb[p] != 0) : (va[p] != 0 && vb[p] != 0);
        check({31'h0, cond_out[0]}, {31'h0, c});
        apb(1'b0, 12'h204, 32'h0);
        check(rd, {31'h0, c});
      end
    $display("test conditions done");
    sig_in[0] <= 16'h0BB8;
    sig_in[1] <= 16'h1388;
    for (int o3 = 0; o3 < 3; o3++)
      for (int k = 0; k < 4; k++)
      begin
        apb(1'b1, 12'h200, ccfg(k[1] ? 4 : 2, k[0] ? 0 : 1, o3));
        wait_eval;
        c = (o3 == 0) ? k[1] | k[0] : (o3 == 1) ? k[1] & k[0] : k[1] ^ k[0];
        check({31'h0, cond_out[0]}, {31'h0, c});
      end
    apb(1'b1, 12'h200, ccfg(4, 1, 3));
    wait_eval;
    check({31'h0, cond_out[0]}, 32'h1);
    apb(1'b1, 12'h240, 32'h000A_0009);
    wait_eval;
    check({31'h0, cond_out[1]}, 32'h1);
    $display("test combiner done");
    stop_test;
  end
endmodule
